// ### include/csrc_pkg.sv
package csrc_pkg;

    // Command codes of the word registers.
    localparam logic [7:0] CSRC_CMD_CHARGE_CURRENT = 8'h14;
    localparam logic [7:0] CSRC_CMD_SYS_VOLTAGE = 8'h15;
    localparam logic [7:0] CSRC_CMD_CONTROL = 8'h3D;
    localparam logic [7:0] CSRC_CMD_INPUT_LIMIT = 8'h3F;

    // Current DAC field: bits 12..7 of a current word, each bit 128 mA upward.
    localparam int CSRC_DAC_LSB = 7;
    localparam int CSRC_DAC_MSB = 12;
    localparam int CSRC_DAC_W = 6;
    localparam logic [CSRC_DAC_W-1:0] CSRC_DAC_MAX = 6'h3F;

    // Control register bit positions.
    localparam int CSRC_CTL_FREQ_100K = 0;
    localparam int CSRC_CTL_FREQ_50K = 1;
    localparam int CSRC_CTL_ISOLATE = 2;
    localparam int CSRC_CTL_LOW_POWER = 4;
    localparam int CSRC_CTL_ADAPTER = 6;
    localparam int CSRC_CTL_TRICKLE = 7;
    localparam int CSRC_CTL_RW_W = 6;

    // Values after bus supply power-up.
    localparam logic [15:0] CSRC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CSRC_CHARGE_RESET = 16'h0000;
    localparam logic [15:0] CSRC_INPUT_LIMIT_RESET = 16'h0000;
    localparam logic [15:0] CSRC_SYS_VOLTAGE_RESET = 16'h0000;

    // Charger watchdog: 175 s at a 100 MHz clock.
    localparam longint CSRC_CLK_HZ = 100_000_000;
    localparam longint CSRC_TIMEOUT_S = 175;
    localparam int CSRC_TMO_W = 36;
    localparam logic [CSRC_TMO_W-1:0] CSRC_TIMEOUT_CYCLES =
        CSRC_TMO_W'(CSRC_TIMEOUT_S * CSRC_CLK_HZ);

    typedef enum logic [1:0] {
        CSRC_FREQ_NORMAL = 2'b00,
        CSRC_FREQ_100K = 2'b01,
        CSRC_FREQ_50K = 2'b11
    } csrc_freq_t;

    typedef enum logic [2:0] {
        CSRC_WS_IDLE = 3'b000,
        CSRC_WS_CMD = 3'b001,
        CSRC_WS_LOW = 3'b010,
        CSRC_WS_HIGH = 3'b011,
        CSRC_WS_FULL = 3'b100,
        CSRC_WS_OVER = 3'b101,
        CSRC_WS_READ = 3'b110
    } csrc_wstate_t;

    // Byte events from the bus framing layer.
    typedef struct packed {
        logic start;
        logic is_read;
        logic byte_valid;
        logic [7:0] byte_data;
        logic read_req;
        logic stop;
    } csrc_frame_t;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [15:0] word;
    } csrc_commit_t;

    // Requests above the top of the DAC range saturate at full scale.
    function automatic logic [CSRC_DAC_W-1:0] csrc_dac_code(input logic [15:0] word);
        if (word[15:CSRC_DAC_MSB+1] != 3'h0) begin
            return CSRC_DAC_MAX;
        end
        return word[CSRC_DAC_MSB:CSRC_DAC_LSB];
    endfunction : csrc_dac_code

endpackage : csrc_pkg

// ### logic/csrc_register_control.sv
`timescale 1ns/1ps
module csrc_register_control #(
    parameter logic [csrc_pkg::CSRC_TMO_W-1:0] TIMEOUT_CYCLES = csrc_pkg::CSRC_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire csrc_pkg::csrc_frame_t frame,
    input wire logic adapter_present_in,
    input wire logic trickle_in,
    output logic [7:0] rd_byte,
    output logic rd_valid,
    output logic [csrc_pkg::CSRC_DAC_W-1:0] input_limit_dac_field,
    output logic [csrc_pkg::CSRC_DAC_W-1:0] charge_dac_field,
    output logic [15:0] system_voltage_ceiling,
    output csrc_pkg::csrc_freq_t freq_sel,
    output logic adapter_switch_gate_out,
    output logic adapter_switch_gate_oe_n,
    output logic monitor_power_down,
    output logic battery_switch_gate,
    output logic charge_enable,
    output logic charge_timed_out,
    output logic system_regulation_on
);
    import csrc_pkg::*;

    csrc_commit_t commit;
    logic [7:0] pointer;
    logic [15:0] rd_word;
    logic [15:0] input_limit_word;
    logic [15:0] charge_current_setting;
    logic [CSRC_CTL_RW_W-1:0] control_rw;
    logic adapter_present_flag;
    logic trickle_flag;
    logic [15:0] control_flags;
    logic [CSRC_TMO_W-1:0] timeout_count;
    logic charge_write;
    logic timeout_hit;
    logic next_charge_enable;
    csrc_freq_t next_freq;

    csrc_word_assembler u_word (
        .clk(clk),
        .rst(rst),
        .frame(frame),
        .rd_word(rd_word),
        .commit(commit),
        .pointer(pointer),
        .rd_byte(rd_byte),
        .rd_valid(rd_valid)
    );

    function automatic logic commit_to(input csrc_commit_t c, input logic [7:0] cmd);
        return c.valid && c.cmd == cmd;
    endfunction : commit_to

    // Status inputs are sampled so the read-only bits reflect device state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adapter_present_flag <= CSRC_CONTROL_RESET[CSRC_CTL_ADAPTER];
            trickle_flag <= CSRC_CONTROL_RESET[CSRC_CTL_TRICKLE];
        end else begin
            adapter_present_flag <= adapter_present_in;
            trickle_flag <= trickle_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_limit_word <= CSRC_INPUT_LIMIT_RESET;
        end else if (commit_to(commit, CSRC_CMD_INPUT_LIMIT)) begin
            input_limit_word <= commit.word;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_current_setting <= CSRC_CHARGE_RESET;
        end else if (commit_to(commit, CSRC_CMD_CHARGE_CURRENT)) begin
            charge_current_setting <= commit.word;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_voltage_ceiling <= CSRC_SYS_VOLTAGE_RESET;
        end else if (commit_to(commit, CSRC_CMD_SYS_VOLTAGE)) begin
            system_voltage_ceiling <= commit.word;
        end
    end

    // Only the writable low six bits are stored; bits 6 and 7 ignore writes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_rw <= CSRC_CONTROL_RESET[CSRC_CTL_RW_W-1:0];
        end else if (commit_to(commit, CSRC_CMD_CONTROL)) begin
            control_rw <= commit.word[CSRC_CTL_RW_W-1:0];
        end
    end

    always_comb begin
        control_flags = 16'h0000;
        control_flags[CSRC_CTL_RW_W-1:0] = control_rw;
        control_flags[CSRC_CTL_ADAPTER] = adapter_present_flag;
        control_flags[CSRC_CTL_TRICKLE] = trickle_flag;
    end

    // Unmapped command codes read as zero.
    always_comb begin
        case (pointer)
            CSRC_CMD_CHARGE_CURRENT: rd_word = charge_current_setting;
            CSRC_CMD_SYS_VOLTAGE: rd_word = system_voltage_ceiling;
            CSRC_CMD_CONTROL: rd_word = control_flags;
            CSRC_CMD_INPUT_LIMIT: rd_word = input_limit_word;
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_limit_dac_field <= '0;
            charge_dac_field <= '0;
        end else begin
            input_limit_dac_field <= csrc_dac_code(input_limit_word);
            charge_dac_field <= csrc_dac_code(charge_current_setting);
        end
    end

    always_comb begin
        case ({control_rw[CSRC_CTL_FREQ_50K], control_rw[CSRC_CTL_FREQ_100K]})
            2'b01: next_freq = CSRC_FREQ_100K;
            2'b11: next_freq = CSRC_FREQ_50K;
            default: next_freq = CSRC_FREQ_NORMAL;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_sel <= CSRC_FREQ_NORMAL;
            adapter_switch_gate_out <= 1'b0;
            adapter_switch_gate_oe_n <= 1'b0;
            monitor_power_down <= 1'b0;
        end else begin
            freq_sel <= next_freq;
            adapter_switch_gate_out <= adapter_present_flag;
            adapter_switch_gate_oe_n <= control_rw[CSRC_CTL_ISOLATE];
            monitor_power_down <= control_rw[CSRC_CTL_LOW_POWER];
        end
    end

    // Watchdog runs only while the adapter is present.
    assign charge_write = commit_to(commit, CSRC_CMD_CHARGE_CURRENT)
        || commit_to(commit, CSRC_CMD_SYS_VOLTAGE);
    assign timeout_hit = adapter_present_flag && timeout_count == TIMEOUT_CYCLES - 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_count <= '0;
        end else if (charge_write || !adapter_present_flag) begin
            timeout_count <= '0;
        end else if (timeout_count != TIMEOUT_CYCLES) begin
            timeout_count <= timeout_count + 1'b1;
        end
    end

    // Expiry wins over a rewrite arriving in the same cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_timed_out <= 1'b0;
        end else if (timeout_hit) begin
            charge_timed_out <= 1'b1;
        end else if (charge_write) begin
            charge_timed_out <= 1'b0;
        end
    end

    assign next_charge_enable = adapter_present_flag && !charge_timed_out
        && charge_dac_field != '0;

    // The battery switch gate is high when the switch is off.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_enable <= 1'b0;
            battery_switch_gate <= 1'b1;
            system_regulation_on <= 1'b1;
        end else begin
            charge_enable <= next_charge_enable;
            battery_switch_gate <= adapter_present_flag && !next_charge_enable;
            system_regulation_on <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_limit_write;
        commit_to(commit, CSRC_CMD_INPUT_LIMIT);
    endsequence

    property p_dac_field;
        logic [15:0] w;
        (s_limit_write, w = commit.word) ##1 w[15:13] == 3'h0
            |=> input_limit_dac_field == w[12:7];
    endproperty
    a_dac_field: assert property (p_dac_field) else $error("input DAC field wrong");

    property p_dac_weight;
        logic [15:0] w;
        (s_limit_write, w = commit.word) ##1 w[15:13] == 3'h0
            |=> {input_limit_dac_field, 7'h00} == {w[12:7], 7'h00};
    endproperty
    a_dac_weight: assert property (p_dac_weight) else $error("input DAC weight wrong");

    property p_dac_clamp;
        (s_limit_write and commit.word[15:13] != 3'h0) |=> ##1 input_limit_dac_field == 6'h3F;
    endproperty
    a_dac_clamp: assert property (p_dac_clamp) else $error("input limit not clamped");

    property p_readback;
        logic [15:0] w;
        (s_limit_write, w = commit.word) |=> input_limit_word == w;
    endproperty
    a_readback: assert property (p_readback) else $error("input limit not stored");

    property p_freq;
        control_rw[1:0] == 2'b11 |=> freq_sel == CSRC_FREQ_50K;
    endproperty
    a_freq: assert property (p_freq) else $error("50 kHz not selected");

    property p_isolate;
        control_rw[CSRC_CTL_ISOLATE] |=> adapter_switch_gate_oe_n;
    endproperty
    a_isolate: assert property (p_isolate) else $error("adapter gate still driven");

    property p_read_only;
        commit_to(commit, CSRC_CMD_CONTROL) |=>
            control_flags[7:6] == $past({trickle_in, adapter_present_in});
    endproperty
    a_read_only: assert property (p_read_only) else $error("status bits were written");

    property p_timeout_off;
        charge_timed_out && adapter_present_flag |=> battery_switch_gate && !charge_enable;
    endproperty
    a_timeout_off: assert property (p_timeout_off) else $error("charging after timeout");

    property p_no_adapter;
        !adapter_present_flag |=> !battery_switch_gate;
    endproperty
    a_no_adapter: assert property (p_no_adapter) else $error("battery switch off");

    property p_regulate;
        charge_timed_out |-> system_regulation_on;
    endproperty
    a_regulate: assert property (p_regulate) else $error("regulation stopped");

    property p_restart;
        charge_write |=> timeout_count == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("timeout not restarted");

endmodule : csrc_register_control

// ### logic/csrc_word_assembler.sv
`timescale 1ns/1ps
module csrc_word_assembler (
    input wire logic clk,
    input wire logic rst,
    input wire csrc_pkg::csrc_frame_t frame,
    input wire logic [15:0] rd_word,
    output csrc_pkg::csrc_commit_t commit,
    output logic [7:0] pointer,
    output logic [7:0] rd_byte,
    output logic rd_valid
);
    import csrc_pkg::*;

    csrc_wstate_t state;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    logic [1:0] rd_index;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CSRC_WS_IDLE;
        end else if (frame.start) begin
            state <= frame.is_read ? CSRC_WS_READ : CSRC_WS_CMD;
        end else if (frame.stop) begin
            state <= CSRC_WS_IDLE;
        end else if (frame.byte_valid) begin
            case (state)
                CSRC_WS_CMD: state <= CSRC_WS_LOW;
                CSRC_WS_LOW: state <= CSRC_WS_HIGH;
                CSRC_WS_HIGH: state <= CSRC_WS_FULL;
                CSRC_WS_FULL: state <= CSRC_WS_OVER;
                default: state <= state;
            endcase
        end
    end

    // The command byte also sets the pointer used by a later read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pointer <= 8'h00;
            low_byte <= 8'h00;
            high_byte <= 8'h00;
        end else if (frame.byte_valid && !frame.start && !frame.stop) begin
            if (state == CSRC_WS_CMD) begin
                pointer <= frame.byte_data;
            end
            if (state == CSRC_WS_LOW) begin
                low_byte <= frame.byte_data;
            end
            if (state == CSRC_WS_HIGH) begin
                high_byte <= frame.byte_data;
            end
        end
    end

    // A write lands only at the stop, and only with exactly two data bytes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            commit <= '0;
        end else begin
            commit.valid <= frame.stop && !frame.start && state == CSRC_WS_FULL;
            commit.cmd <= pointer;
            commit.word <= {high_byte, low_byte};
        end
    end

    // Reads return the low byte first, then the high byte, then zeros.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_index <= 2'h0;
            rd_byte <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= frame.read_req && state == CSRC_WS_READ;
            if (frame.start) begin
                rd_index <= 2'h0;
            end else if (frame.read_req && state == CSRC_WS_READ) begin
                rd_index <= (rd_index == 2'h2) ? rd_index : rd_index + 2'h1;
                case (rd_index)
                    2'h0: rd_byte <= rd_word[7:0];
                    2'h1: rd_byte <= rd_word[15:8];
                    default: rd_byte <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_single_word;
        frame.stop && state != CSRC_WS_FULL |=> !commit.valid;
    endproperty
    a_single_word: assert property (p_single_word) else $error("commit without two bytes");

    sequence s_first_read;
        frame.read_req && state == CSRC_WS_READ && rd_index == 2'h0 && !frame.start;
    endsequence
    property p_low_first;
        logic [7:0] lo;
        (s_first_read, lo = rd_word[7:0]) |=> rd_valid && rd_byte == lo;
    endproperty
    a_low_first: assert property (p_low_first) else $error("read did not start low byte");

endmodule : csrc_word_assembler

// ### sim/csrc_host_model.sv
`timescale 1ns/1ps
module csrc_host_model (
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_byte,
    output csrc_pkg::csrc_frame_t frame
);
    import csrc_pkg::*;

    logic [7:0] last_data = 8'h00;

    initial begin
        frame = '0;
    end

    // A released data line shows the inverse of its last byte, never a stale copy.
    task automatic put(input logic st, input logic rd, input logic bv, input logic [7:0] d,
                       input logic rq, input logic sp);
        csrc_frame_t f;
        f.start = st;
        f.is_read = rd;
        f.byte_valid = bv;
        f.byte_data = bv ? d : ~last_data;
        f.read_req = rq;
        f.stop = sp;
        if (bv) begin
            last_data = d;
        end
        @(posedge clk);
        frame <= f;
    endtask : put

    task automatic write_raw(input logic [7:0] cmd, input logic [7:0] data[$]);
        put(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        put(1'b0, 1'b0, 1'b1, cmd, 1'b0, 1'b0);
        foreach (data[i]) begin
            put(1'b0, 1'b0, 1'b1, data[i], 1'b0, 1'b0);
        end
        put(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
        put(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    endtask : write_raw

    task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
        logic [7:0] q[$];
        q.push_back(w[7:0]);
        q.push_back(w[15:8]);
        write_raw(cmd, q);
    endtask : write_word

    task automatic read_word(input logic [7:0] cmd, output logic [15:0] w, output logic ok);
        logic got;
        ok = 1'b1;
        w = 16'h0000;
        put(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        put(1'b0, 1'b0, 1'b1, cmd, 1'b0, 1'b0);
        put(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
        put(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            put(1'b0, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0);
            put(1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
            got = 1'b0;
            for (int t = 0; t < 4 && !got; t++) begin
                @(posedge clk);
                if (rd_valid === 1'b1) begin
                    w = (k == 0) ? {w[15:8], rd_byte} : {rd_byte, w[7:0]};
                    got = 1'b1;
                end
            end
            ok = ok & got;
        end
        put(1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1);
        put(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    endtask : read_word
endmodule : csrc_host_model

// ### sim/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) check(16'(got), 16'(exp))
module tb;
    import csrc_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic adapter = 1'b0;
    logic trickle = 1'b0;
    csrc_frame_t frame;
    logic [7:0] rd_byte;
    logic rd_valid, gate_out, gate_oe_n, pdown, bat_gate, chg_en, timed_out, reg_on;
    logic [CSRC_DAC_W-1:0] in_dac, chg_dac;
    logic [15:0] sys_v;
    csrc_freq_t freq;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h0000B7A7;
    logic [15:0] corner [6] = '{16'h41A0, 16'h1F80, 16'h2000, 16'h007F, 16'hFFFF, 16'h0080};

    always #5 clk = ~clk;

    csrc_register_control #(.TIMEOUT_CYCLES(36'h32)) dut_u (
        .clk(clk), .rst(rst), .frame(frame), .adapter_present_in(adapter),
        .trickle_in(trickle), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .input_limit_dac_field(in_dac), .charge_dac_field(chg_dac),
        .system_voltage_ceiling(sys_v), .freq_sel(freq), .adapter_switch_gate_out(gate_out),
        .adapter_switch_gate_oe_n(gate_oe_n), .monitor_power_down(pdown),
        .battery_switch_gate(bat_gate), .charge_enable(chg_en),
        .charge_timed_out(timed_out), .system_regulation_on(reg_on)
    );

    csrc_host_model host_u (.clk(clk), .rd_valid(rd_valid), .rd_byte(rd_byte), .frame(frame));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    function automatic logic [5:0] exp_dac(input logic [15:0] w);
        return (w[15:13] != 3'h0) ? 6'h3F : w[12:7];
    endfunction : exp_dac

    function automatic csrc_freq_t exp_freq(input logic [15:0] w);
        if (w[1:0] == 2'b01) return CSRC_FREQ_100K;
        if (w[1:0] == 2'b11) return CSRC_FREQ_50K;
        return CSRC_FREQ_NORMAL;
    endfunction : exp_freq

    function automatic logic [15:0] exp_ctl(input logic [15:0] w, input logic a, input logic t);
        return {8'h00, t, a, w[5:0]};
    endfunction : exp_ctl

    task automatic results();
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Outputs settle three edges after the stop event, so one spare edge is allowed; charge_enable and battery_switch_gate settle on the fourth, with none spare.
    task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
        host_u.write_word(cmd, w);
        repeat (4) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] cmd, output logic [15:0] w);
        logic ok;
        host_u.read_word(cmd, w, ok);
        if (!ok) begin
            fail_count++;
            results();
        end
    endtask : rd

    initial begin
        logic [15:0] w;
        logic [15:0] r;
        logic [7:0] q[$];
        int t;
        repeat (6) @(posedge clk);
        `CHK(bat_gate, 1);
        `CHK(chg_en, 0);
        `CHK(in_dac, 0);
        `CHK(freq, CSRC_FREQ_NORMAL);
        `CHK(gate_oe_n, 0);
        `CHK(pdown, 0);
        `CHK(reg_on, 1);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(bat_gate, 0);
        rd(CSRC_CMD_CONTROL, r);
        `CHK(r, CSRC_CONTROL_RESET);
        rd(CSRC_CMD_CHARGE_CURRENT, r);
        `CHK(r, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            w = (i < 6) ? corner[i] : seed[15:0];
            wr(CSRC_CMD_INPUT_LIMIT, w);
            `CHK(in_dac, exp_dac(w));
            rd(CSRC_CMD_INPUT_LIMIT, r);
            `CHK(r, w);
        end
        q.push_back(8'h5A);
        host_u.write_raw(CSRC_CMD_INPUT_LIMIT, q);
        q.push_back(8'h12);
        q.push_back(8'h34);
        host_u.write_raw(CSRC_CMD_INPUT_LIMIT, q);
        rd(CSRC_CMD_INPUT_LIMIT, r);
        `CHK(r, w);
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            w = (i < 4) ? {14'h0, i[1:0]} : seed[15:0];
            adapter <= seed[16];
            trickle <= seed[17];
            wr(CSRC_CMD_CONTROL, w);
            `CHK(freq, exp_freq(w));
            `CHK(gate_oe_n, w[2]);
            `CHK(pdown, w[4]);
            if (gate_oe_n === 1'b0) begin
                `CHK(gate_out, adapter);
            end
            rd(CSRC_CMD_CONTROL, r);
            `CHK(r, exp_ctl(w, adapter, trickle));
        end
        adapter <= 1'b0;
        wr(CSRC_CMD_CONTROL, 16'h0000);
        adapter <= 1'b1;
        wr(CSRC_CMD_CHARGE_CURRENT, 16'h0400);
        `CHK(chg_dac, 6'h08);
        `CHK(chg_en, 1);
        repeat (30) @(posedge clk);
        wr(CSRC_CMD_SYS_VOLTAGE, 16'h3000);
        `CHK(sys_v, 16'h3000);
        repeat (30) @(posedge clk);
        `CHK(timed_out, 0);
        for (t = 0; t < 80 && timed_out !== 1'b1; t++) begin
            @(posedge clk);
        end
        `CHK(timed_out, 1);
        `CHK(t > 5 && t < 25, 1);
        repeat (3) @(posedge clk);
        `CHK(bat_gate, 1);
        `CHK(chg_en, 0);
        `CHK(reg_on, 1);
        `CHK(sys_v, 16'h3000);
        rd(CSRC_CMD_SYS_VOLTAGE, r);
        `CHK(r, 16'h3000);
        wr(CSRC_CMD_CHARGE_CURRENT, 16'h0400);
        `CHK(timed_out, 0);
        `CHK(chg_en, 1);
        adapter <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(bat_gate, 0);
        wr(CSRC_CMD_CONTROL, 16'h0017);
        `CHK(pdown, 1);
        // A second bus supply power-up in mid-run must restore every default.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(pdown, 0);
        `CHK(freq, CSRC_FREQ_NORMAL);
        `CHK(chg_dac, 0);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(CSRC_CMD_CONTROL, r);
        `CHK(r, exp_ctl(CSRC_CONTROL_RESET, 1'b0, trickle));
        rd(CSRC_CMD_CHARGE_CURRENT, r);
        `CHK(r, CSRC_CHARGE_RESET);
        results();
    end
endmodule : tb
